/* File: rtl/ocdc_defines.vh */
// Constants for the oscillator clock divider control block.
`ifndef OCDC_DEFINES_VH
`define OCDC_DEFINES_VH

// Register byte addresses and alias offsets.
`define OCDC_OSC_BASE 32'h0000_F000
`define OCDC_REFO_BASE 32'h0000_F020
`define OCDC_KEY_ADDR 32'h0000_F0F0
`define OCDC_BLK_MASK 32'hFFFF_FFF0
`define OCDC_OP_WRITE 2'h0
`define OCDC_OP_CLR 2'h1
`define OCDC_OP_SET 2'h2
`define OCDC_OP_INV 2'h3

// Register select codes.
`define OCDC_SEL_NONE 2'h0
`define OCDC_SEL_OSC 2'h1
`define OCDC_SEL_REFO 2'h2
`define OCDC_SEL_KEY 2'h3

// Unlock keys.
`define OCDC_KEY1 32'hC0DE_5A01
`define OCDC_KEY2 32'hC0DE_A502

// Field positions of the oscillator control register.
`define OCDC_PLLODIV_HI 29
`define OCDC_PLLODIV_LO 27
`define OCDC_FRCDIV_HI 26
`define OCDC_FRCDIV_LO 24
`define OCDC_SECONDARY_OSC_READY_BIT 22
`define OCDC_PBRDY_BIT 21
`define OCDC_PBDIV_HI 20
`define OCDC_PBDIV_LO 19
`define OCDC_PLLMULT_HI 18
`define OCDC_PLLMULT_LO 16
`define OCDC_COSC_HI 14
`define OCDC_COSC_LO 12
`define OCDC_NOSC_HI 10
`define OCDC_NOSC_LO 8
`define OCDC_SELECTION_LOCK_BIT 7
`define OCDC_ULOCK_BIT 6
`define OCDC_SLOCK_BIT 5
`define OCDC_SLPEN_BIT 4
`define OCDC_CF_BIT 3
`define OCDC_UFRCEN_BIT 2
`define OCDC_SOSCEN_BIT 1
`define OCDC_SWITCH_ENABLE_BIT 0

// Masks of writable, lockable and divisor bits, and reset values.
`define OCDC_WR_MASK 32'h3F1F_079F
`define OCDC_LOCK_MASK 32'h3807_0700
`define OCDC_PBDIV_MASK 32'h0018_0000
`define OCDC_CTL_RST 32'h0118_0000
`define OCDC_REFO_RST 32'h0000_0000

// Divider exponents, codes and widths, and the bus transfer code.
`define OCDC_EXP_W 4
`define OCDC_EXP_256 4'h8
`define OCDC_CODE_MAX 3'h7
`define OCDC_HTRANS_NONSEQ 2'h2

`endif

/* File: rtl/ocdc_clk_div.v */
// Power-of-two tick divider that changes ratio only at a period boundary.
`timescale 1ns/1ns
`default_nettype none
`include "ocdc_defines.vh"

module ocdc_clk_div #(
	parameter CNT_W = 8
) (
	input wire hclk, // system clock
	input wire hresetn, // asynchronous reset, active low
	input wire in_tick, // one source clock edge, as an enable
	input wire [`OCDC_EXP_W-1:0] div_exp, // requested divide exponent
	output reg out_tick, // one divided clock edge
	output wire busy // requested ratio not yet in use
);

	reg [CNT_W-1:0] cnt_r;
	reg [`OCDC_EXP_W-1:0] cur_r;
	wire [CNT_W-1:0] limit;

	assign limit = ({{(CNT_W-1){1'b0}}, 1'b1} << cur_r) - {{(CNT_W-1){1'b0}}, 1'b1};
	assign busy = (div_exp != cur_r);

	// The new ratio is adopted only when a full period ends, so no short pulse appears.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_r <= {CNT_W{1'b0}};
			cur_r <= {`OCDC_EXP_W{1'b0}};
			out_tick <= 1'b0;
		end else if (in_tick) begin
			if (cnt_r >= limit) begin // [R14]
				cnt_r <= {CNT_W{1'b0}};
				cur_r <= div_exp;
				out_tick <= 1'b1;
			end else begin
				cnt_r <= cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
				out_tick <= 1'b0;
			end
		end else begin
			out_tick <= 1'b0;
		end
	end

endmodule
`default_nettype wire

/* File: rtl/ocdc_top.v */
// Oscillator control register, clock dividers and register bus slave.
//
// Contract
// R1: PLL output divider bits 29:27 divide by 1,2,4,8,16,32,64,256.
// R2: Fast RC divider bits 26:24 divide likewise; reset code 001.
// R3: Bit 22 reads 1 only while the secondary oscillator is stable.
// R4: Bit 21 reads 1 when the peripheral divisor may be written.
// R5: Bits 20:19 divide system clock by 1,2,4,8; default 11.
// R6: Oscillator control writes are accepted only after the unlock sequence.
// R7: Bits 31:30 and 23 read zero and ignore writes.
// R8: Divider, multiplier, divisor and source fields load from fuses after reset.
// R9: Clear, set and invert aliases change only bits written as one.
// R10: Aliases sit at base plus 0x4, 0x8 and 0xC.
// R11: Switch enable starts a switch; hardware clears it when done.
// R12: Locked selection fields when monitor config is 1x and lock bit set.
// R13: Divisor write while not ready leaves the divisor unchanged.
// R14: Divisor changes produce no runt pulses on derived clocks.
`timescale 1ns/1ns
`default_nettype none
`include "ocdc_defines.vh"

module ocdc_top (
	input wire hclk, // system clock
	input wire hresetn, // asynchronous reset, active low
	input wire hsel, // slave select
	input wire [31:0] haddr, // byte address
	input wire [1:0] htrans, // transfer type
	input wire hwrite, // write when high
	input wire [2:0] hsize, // transfer size, word only
	input wire hready, // bus ready
	input wire [31:0] hwdata, // write data
	output reg [31:0] hrdata, // read data
	output wire hreadyout, // slave ready
	output wire hresp, // always OKAY
	input wire [2:0] fuse_pll_output_divider, // fuse value for the PLL divider
	input wire [2:0] fuse_pll_multiplier, // fuse value for the multiplier
	input wire [1:0] fuse_periph_clock_divisor, // fuse value for the divisor
	input wire [2:0] fuse_new_source_select, // fuse value for the source
	input wire fuse_sosc_enable, // fuse value for the secondary enable
	input wire [1:0] switch_monitor_config, // switch and monitor config
	input wire secondary_osc_stable, // secondary oscillator stable level
	input wire pll_locked, // PLL lock level
	input wire usb_pll_locked, // USB PLL lock level
	input wire clock_fail_event, // fail monitor pulse
	input wire switch_done, // switch finished pulse
	input wire pll_tick, // PLL output edge enable
	input wire fast_internal_rc_tick, // fast RC edge enable
	output wire pll_div_tick, // divided PLL edge
	output wire fast_rc_div_tick, // divided fast RC edge
	output wire peripheral_bus_clock_tick, // peripheral clock edge
	output wire switch_request, // switch in progress level
	output wire [2:0] new_source_select, // requested source
	output wire [2:0] current_source_select, // source in use
	output wire [2:0] pll_multiplier, // PLL multiplier code
	output wire sleep_enable, // sleep on wait
	output wire usb_fast_rc_enable, // fast RC as USB clock
	output wire sosc_enable, // secondary oscillator enable
	output wire [31:0] refclk_control // reference clock control word
);

	localparam ST_LOCKED = 3'b001;
	localparam ST_HALF = 3'b010;
	localparam ST_OPEN = 3'b100;

	reg [31:0] ctl_r;
	reg [31:0] ctl_nxt;
	reg [31:0] refo_r;
	reg [31:0] refo_nxt;
	reg [2:0] cosc_r;
	reg [2:0] ulk_r;
	reg [2:0] ulk_nxt;
	reg fuse_load_r;
	reg wr_r;
	reg rd_r;
	reg [1:0] sel_r;
	reg [1:0] op_r;
	reg rd_wait_r;
	reg [31:0] osc_view;
	reg [31:0] wmask;
	reg [31:0] newval;
	wire addr_ok;
	wire rd_first;
	wire osc_wr;
	wire key_wr;
	wire lock_on;
	wire pb_busy;
	wire [`OCDC_EXP_W-1:0] pll_exp;
	wire [`OCDC_EXP_W-1:0] frc_exp;
	wire [`OCDC_EXP_W-1:0] pb_exp;

	// Divider code to exponent; the top code jumps to 256.
	function [`OCDC_EXP_W-1:0] code_to_exp;
		input [2:0] code;
		begin
			if (code == `OCDC_CODE_MAX)
				code_to_exp = `OCDC_EXP_256;
			else
				code_to_exp = {1'b0, code};
		end
	endfunction

	// Address decode shared by every register; the key word has a single address.
	function [1:0] reg_select;
		input [31:0] a;
		begin
			if ((a & `OCDC_BLK_MASK) == `OCDC_OSC_BASE)
				reg_select = `OCDC_SEL_OSC;
			else if ((a & `OCDC_BLK_MASK) == `OCDC_REFO_BASE)
				reg_select = `OCDC_SEL_REFO;
			else if (a == `OCDC_KEY_ADDR)
				reg_select = `OCDC_SEL_KEY;
			else
				reg_select = `OCDC_SEL_NONE;
		end
	endfunction

	// Alias action on a register: plain write, clear, set or invert.
	function [31:0] alias_apply;
		input [31:0] old;
		input [31:0] wd;
		input [1:0] op;
		begin
			case (op)
				`OCDC_OP_CLR: alias_apply = old & ~wd; // [R9]
				`OCDC_OP_SET: alias_apply = old | wd; // [R9]
				`OCDC_OP_INV: alias_apply = old ^ wd; // [R9]
				default: alias_apply = wd;
			endcase
		end
	endfunction

	assign addr_ok = hsel && hready && (htrans == `OCDC_HTRANS_NONSEQ || htrans[1]);
	// The wait state sits in the first read data cycle, while hrdata is being loaded.
	// Stalling there keeps the master from taking the previous read's data.
	assign rd_first = rd_r && !rd_wait_r;
	assign hreadyout = ~rd_first;

	// Every transfer completes with OKAY, unmapped ones included.
	assign hresp = 1'b0;

	// Write strobes for the key word and the oscillator control register and its aliases.
	// Control writes count only once the key sequence has opened the register.
	assign key_wr = wr_r && (sel_r == `OCDC_SEL_KEY);
	assign osc_wr = wr_r && (sel_r == `OCDC_SEL_OSC) && (ulk_r == ST_OPEN);

	// Address phase capture; the alias is picked from address bits 3:2.
	// A new address phase is taken only while the slave is not stalling.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_r <= 1'b0;
			rd_r <= 1'b0;
			sel_r <= `OCDC_SEL_NONE;
			op_r <= `OCDC_OP_WRITE;
		end else if (hreadyout) begin
			wr_r <= addr_ok && hwrite;
			rd_r <= addr_ok && !hwrite;
			sel_r <= addr_ok ? reg_select(haddr) : `OCDC_SEL_NONE;
			op_r <= haddr[3:2]; // [R10]
		end
	end

	// Reads take one wait state so a write just before is always seen.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rd_wait_r <= 1'b0;
			hrdata <= 32'h0000_0000;
		end else begin
			rd_wait_r <= rd_first;
			// Unmapped reads return zero.
			if (rd_first) begin
				case (sel_r)
					`OCDC_SEL_OSC: hrdata <= osc_view;
					`OCDC_SEL_REFO: hrdata <= refo_r;
					`OCDC_SEL_KEY: hrdata <= {31'h0000_0000, ulk_r == ST_OPEN};
					default: hrdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	// Read view: stored writable bits plus live status; holes stay zero.
	always @* begin
		osc_view = ctl_r & `OCDC_WR_MASK; // [R7]
		osc_view[`OCDC_SECONDARY_OSC_READY_BIT] = secondary_osc_stable; // [R3]
		osc_view[`OCDC_PBRDY_BIT] = ~pb_busy; // [R4]
		osc_view[`OCDC_COSC_HI:`OCDC_COSC_LO] = cosc_r;
		osc_view[`OCDC_ULOCK_BIT] = usb_pll_locked;
		osc_view[`OCDC_SLOCK_BIT] = pll_locked;
	end

	// Unlock sequence: two keys in order; any other key write relocks.
	always @* begin
		ulk_nxt = ulk_r;
		// A stray key write drops the unlock, so a runaway program cannot keep it open.
		if (key_wr) begin
			case (ulk_r)
				ST_LOCKED: ulk_nxt = (hwdata == `OCDC_KEY1) ? ST_HALF : ST_LOCKED;
				ST_HALF: ulk_nxt = (hwdata == `OCDC_KEY2) ? ST_OPEN : ST_LOCKED;
				ST_OPEN: ulk_nxt = (hwdata == `OCDC_KEY1) ? ST_HALF : ST_LOCKED;
				default: ulk_nxt = ST_LOCKED;
			endcase
		end
	end

	assign lock_on = switch_monitor_config[1] && ctl_r[`OCDC_SELECTION_LOCK_BIT];

	always @* begin
		wmask = `OCDC_WR_MASK; // [R7]
		if (lock_on)
			wmask = wmask & ~`OCDC_LOCK_MASK; // [R12]
		// A pending ratio change masks divisor writes; software must poll the ready flag.
		if (pb_busy)
			wmask = wmask & ~`OCDC_PBDIV_MASK; // [R13]
		newval = alias_apply(ctl_r, hwdata, op_r);
		ctl_nxt = ctl_r;
		if (fuse_load_r) begin
			ctl_nxt[`OCDC_PLLODIV_HI:`OCDC_PLLODIV_LO] = fuse_pll_output_divider; // [R8]
			ctl_nxt[`OCDC_PLLMULT_HI:`OCDC_PLLMULT_LO] = fuse_pll_multiplier; // [R8]
			ctl_nxt[`OCDC_PBDIV_HI:`OCDC_PBDIV_LO] = fuse_periph_clock_divisor; // [R8]
			ctl_nxt[`OCDC_NOSC_HI:`OCDC_NOSC_LO] = fuse_new_source_select; // [R8]
			ctl_nxt[`OCDC_SOSCEN_BIT] = fuse_sosc_enable; // [R8]
		end else if (osc_wr) begin
			ctl_nxt = (ctl_r & ~wmask) | (newval & wmask); // [R6]
		end
		// A switch_done pulse clears the request, unless software sets it from clear
		// in the same cycle; losing that fresh request would stall the next switch.
		if (switch_done && !(osc_wr && newval[`OCDC_SWITCH_ENABLE_BIT] && !ctl_r[`OCDC_SWITCH_ENABLE_BIT]))
			ctl_nxt[`OCDC_SWITCH_ENABLE_BIT] = 1'b0; // [R11]
		// A failure report wins over a software clear in the same cycle.
		if (clock_fail_event)
			ctl_nxt[`OCDC_CF_BIT] = 1'b1;
	end

	// The reference clock word is plain storage with the same aliases.
	always @* begin
		refo_nxt = refo_r;
		if (wr_r && sel_r == `OCDC_SEL_REFO)
			refo_nxt = alias_apply(refo_r, hwdata, op_r); // [R9]
	end

	// Fuses are caught on the first edge after reset release, not by the reset itself.
	// That keeps the reset branch free of anything but constants.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctl_r <= `OCDC_CTL_RST; // [R2] [R5]
			refo_r <= `OCDC_REFO_RST;
			ulk_r <= ST_LOCKED;
			fuse_load_r <= 1'b1;
			cosc_r <= 3'h0;
		end else begin
			ctl_r <= ctl_nxt;
			refo_r <= refo_nxt;
			ulk_r <= ulk_nxt;
			fuse_load_r <= 1'b0;
			if (fuse_load_r)
				cosc_r <= fuse_new_source_select;
			else if (switch_done && ctl_r[`OCDC_SWITCH_ENABLE_BIT])
				cosc_r <= ctl_r[`OCDC_NOSC_HI:`OCDC_NOSC_LO]; // [R11]
		end
	end

	assign pll_exp = code_to_exp(ctl_r[`OCDC_PLLODIV_HI:`OCDC_PLLODIV_LO]); // [R1]
	assign frc_exp = code_to_exp(ctl_r[`OCDC_FRCDIV_HI:`OCDC_FRCDIV_LO]); // [R2]
	assign pb_exp = {2'b00, ctl_r[`OCDC_PBDIV_HI:`OCDC_PBDIV_LO]}; // [R5]

	// The source dividers count enables, so they need no clock of their own.
	ocdc_clk_div #(.CNT_W(8)) u_pll_div (
		.hclk(hclk),
		.hresetn(hresetn),
		.in_tick(pll_tick),
		.div_exp(pll_exp),
		.out_tick(pll_div_tick),
		.busy()
	);

	ocdc_clk_div #(.CNT_W(8)) u_frc_div (
		.hclk(hclk),
		.hresetn(hresetn),
		.in_tick(fast_internal_rc_tick),
		.div_exp(frc_exp),
		.out_tick(fast_rc_div_tick),
		.busy()
	);

	// The peripheral divider counts system clock edges directly.
	ocdc_clk_div #(.CNT_W(8)) u_pb_div (
		.hclk(hclk),
		.hresetn(hresetn),
		.in_tick(1'b1),
		.div_exp(pb_exp),
		.out_tick(peripheral_bus_clock_tick),
		.busy(pb_busy)
	);

	assign switch_request = ctl_r[`OCDC_SWITCH_ENABLE_BIT];
	assign new_source_select = ctl_r[`OCDC_NOSC_HI:`OCDC_NOSC_LO];
	assign current_source_select = cosc_r;
	assign pll_multiplier = ctl_r[`OCDC_PLLMULT_HI:`OCDC_PLLMULT_LO];
	assign sleep_enable = ctl_r[`OCDC_SLPEN_BIT];
	assign usb_fast_rc_enable = ctl_r[`OCDC_UFRCEN_BIT];
	assign sosc_enable = ctl_r[`OCDC_SOSCEN_BIT];
	assign refclk_control = refo_r;

endmodule
`default_nettype wire

/* File: verif/ocdc_top_properties.sv */
// Concurrent checks on the ports of the oscillator clock divider control block.
`timescale 1ns/1ns
`default_nettype none
`include "ocdc_defines.vh"
module ocdc_props (
	input wire hclk, // clock
	input wire hresetn, // reset
	input wire hsel, // select
	input wire [31:0] haddr, // address
	input wire [1:0] htrans, // transfer
	input wire hwrite, // write
	input wire [31:0] hrdata, // read data
	input wire hreadyout, // ready
	input wire hresp, // response
	input wire secondary_osc_stable, // stable
	input wire switch_done, // switch end
	input wire peripheral_bus_clock_tick, // tick
	input wire switch_request, // switch
	input wire [2:0] pll_multiplier // multiplier
);
	wire tk = hsel && hreadyout && htrans[1];
	wire rd_osc = tk && !hwrite && haddr == `OCDC_OSC_BASE;
	reg w_r;
	reg [1:0] up_r;
	reg [3:0] gap_r;
	// The gap stays zero until the first tick, so the interval cut by reset is never judged.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			w_r <= 1'b0;
			up_r <= 2'h0;
			gap_r <= 4'h0;
		end else begin
			w_r <= tk && hwrite;
			up_r <= up_r + {1'b0, up_r != 2'h3};
			if (peripheral_bus_clock_tick)
				gap_r <= 4'h1;
			else if (gap_r != 4'h0 && gap_r != 4'hF)
				gap_r <= gap_r + 4'h1;
		end
	end
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	chk_resp_okay: assert property (hresp == 1'b0)
		else $error("error response seen");
	chk_read_wait: assert property (tk && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");
	chk_unimpl_zero: assert property (
		rd_osc |=> ##1 hrdata[31:30] == 2'h0 && !hrdata[23])
		else $error("unimplemented bits read nonzero");
	chk_sosc_ready: assert property (
		rd_osc && secondary_osc_stable ##1 secondary_osc_stable |=> hrdata[22])
		else $error("ready flag low with stable oscillator");
	chk_pb_gap: assert property (
		peripheral_bus_clock_tick && gap_r != 4'h0 |-> gap_r inside {4'h1, 4'h2, 4'h4, 4'h8})
		else $error("peripheral tick spacing wrong");
	chk_mult_hold: assert property (
		up_r == 2'h3 && !$stable(pll_multiplier) |-> $past(w_r))
		else $error("multiplier changed without a write");
	chk_switch_start: assert property ($rose(switch_request) |-> $past(w_r))
		else $error("switch started without a write");
	chk_switch_end: assert property (
		$fell(switch_request) |-> $past(switch_done) || $past(w_r))
		else $error("switch ended without completion");
endmodule
bind ocdc_top ocdc_props u_props (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hrdata,
	.hreadyout, .hresp, .secondary_osc_stable, .switch_done, .peripheral_bus_clock_tick,
	.switch_request, .pll_multiplier);
`default_nettype wire

/* File: verif/oscillator_clock_divider_control_tb.sv */
// Self-checking bench for the oscillator clock divider control block.
`timescale 1ns/1ns
`default_nettype none
`include "ocdc_defines.vh"
module oscillator_clock_divider_control_tb;
	localparam logic [31:0] osc = `OCDC_OSC_BASE;
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic [1:0] htrans = 2'h0, fpb = 2'h2, smc = 2'h0;
	logic [31:0] haddr = '0, hwdata = '0, q;
	logic [2:0] fpd = 3'h5, fpm = 3'h6, fns = 3'h3;
	logic fse = 1'b1, sos = 1'b1, plk = 1'b1, cfe = 1'b0, sdn = 1'b0;
	int fail_count = 0, checks_done = 0;
	wire hready, hreadyout, hresp, pll_div_tick, fast_rc_div_tick, peripheral_bus_clock_tick;
	wire switch_request, sleep_enable, usb_fast_rc_enable, sosc_enable;
	wire [31:0] hrdata, refclk_control;
	wire [2:0] new_source_select, current_source_select, pll_multiplier;
	assign hready = hreadyout;
	always #2 hclk = ~hclk;
	ocdc_top dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hready,
		.hwdata, .hrdata, .hreadyout, .hresp, .fuse_pll_output_divider(fpd),
		.fuse_pll_multiplier(fpm), .fuse_periph_clock_divisor(fpb),
		.fuse_new_source_select(fns), .fuse_sosc_enable(fse), .switch_monitor_config(smc),
		.secondary_osc_stable(sos), .pll_locked(plk), .usb_pll_locked(1'b0),
		.clock_fail_event(cfe), .switch_done(sdn), .pll_tick(1'b1),
		.fast_internal_rc_tick(1'b1), .pll_div_tick, .fast_rc_div_tick,
		.peripheral_bus_clock_tick, .switch_request, .new_source_select,
		.current_source_select, .pll_multiplier, .sleep_enable, .usb_fast_rc_enable,
		.sosc_enable, .refclk_control);
	task automatic complete_run;
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checks_done++;
		if (s !== e) begin
			fail_count++;
			$display("ERROR %0t: saw %h expected %h", $time, s, e);
		end
	endtask
	// Hold each phase until ready is sampled high; read data is taken at that same edge.
	task automatic bus(input logic [31:0] a, input logic [31:0] d, input logic w);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask
	function automatic logic tick(input int s);
		return s == 0 ? peripheral_bus_clock_tick : s == 1 ? fast_rc_div_tick : pll_div_tick;
	endfunction
	// Two ticks are skipped first, since a new ratio waits for the old period to end.
	task automatic gap(input int s, input int e);
		int n;
		n = 0;
		repeat (2) do @(posedge hclk); while (tick(s) !== 1'b1);
		do begin
			@(posedge hclk);
			n++;
		end while (tick(s) !== 1'b1);
		chk(n, e);
	endtask
	task automatic t_fuse;
		hresetn <= 1'b0;
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (12) @(posedge hclk);
		bus(osc, '0, 1'b0);
		chk(q, {2'h0, fpd, 3'h1, 1'b0, sos, 1'b1, fpb, fpm, 1'b0, fns, 1'b0, fns, 2'h0, plk, 3'h0, fse, 1'b0});
		chk({new_source_select, current_source_select, pll_multiplier}, {fns, fns, fpm});
	endtask
	task automatic t_unlock;
		bus(osc + 32'h8, 32'h10, 1'b1);
		bus(osc, '0, 1'b0);
		chk(q[4], 1'b0);
		bus(`OCDC_KEY_ADDR, `OCDC_KEY1, 1'b1);
		bus(`OCDC_KEY_ADDR, `OCDC_KEY2, 1'b1);
		bus(osc + 32'h8, 32'h10, 1'b1);
		bus(osc, '0, 1'b0);
		chk({q[4], sleep_enable}, 2'h3);
	endtask
	task automatic t_alias;
		bus(osc, 32'hF896_0312, 1'b1);
		bus(osc, '0, 1'b0);
		chk(q, 32'h3876_3332);
		bus(osc + 32'h4, 32'h3800_0010, 1'b1);
		bus(osc + 32'hC, 32'h0100_0000, 1'b1);
		bus(osc + 32'h8, 32'h1, 1'b1);
		bus(osc, '0, 1'b0);
		chk({q, switch_request}, {32'h0176_3323, 1'b1});
		chk({sosc_enable, usb_fast_rc_enable}, 2'h2);
		cfe <= 1'b1;
		sdn <= 1'b1;
		@(posedge hclk);
		cfe <= 1'b0;
		sdn <= 1'b0;
		bus(osc, '0, 1'b0);
		chk(q, 32'h0176_332A);
		bus(32'h0000_F040, '0, 1'b0);
		chk(q, '0);
		bus(`OCDC_REFO_BASE, 32'hA5A5_00FF, 1'b1);
		bus(`OCDC_REFO_BASE + 32'h4, 32'h0000_000F, 1'b1);
		bus(`OCDC_REFO_BASE, '0, 1'b0);
		chk(q, 32'hA5A5_00F0);
		chk(refclk_control, 32'hA5A5_00F0);
	endtask
	task automatic t_div;
		for (int c = 0; c < 8; c++) begin
			bus(osc, {2'h0, c[2:0], c[2:0], 3'h0, c[1:0], 19'h6_0302}, 1'b1);
			gap(1, c == 7 ? 256 : 1 << c);
			gap(2, c == 7 ? 256 : 1 << c);
			if (c < 4)
				gap(0, 1 << c);
		end
	endtask
	task automatic t_busy;
		do @(posedge hclk); while (peripheral_bus_clock_tick !== 1'b1);
		bus(osc, 32'h3F06_0302, 1'b1);
		bus(osc + 32'h8, 32'h0008_0000, 1'b1);
		bus(osc, '0, 1'b0);
		chk(q[21], 1'b0);
		gap(0, 1);
		bus(osc, '0, 1'b0);
		chk(q[21:19], 3'h4);
	endtask
	task automatic t_lock;
		smc <= 2'h2;
		bus(osc + 32'h8, 32'h80, 1'b1);
		bus(osc + 32'h8, 32'h0001_0000, 1'b1);
		bus(osc, '0, 1'b0);
		chk({q[18:16], q[7]}, 4'hD);
	endtask
	initial begin
		t_fuse;
		t_unlock;
		t_alias;
		t_div;
		t_busy;
		t_lock;
		{fpd, fpm, fns, fpb} <= 11'h0B1;
		{fse, sos, plk} <= 3'h0;
		t_fuse;
		complete_run;
	end
	initial begin
		#200000;
		fail_count++;
		complete_run;
	end
endmodule
`default_nettype wire
